// File: rtl/output_stage_control.sv
/*
  Register bank and protection logic for the stereo headphone and class-D
  speaker output stages: routing, attenuation with soft stepping, driver
  power, gain, mute, common mode, short-circuit and thermal handling.
  Assumes register accesses and fault inputs are synchronous to
  i_sys_clk, and that i_arst_n is the device master reset.
*/
`timescale 1ns/1ps
`default_nettype none

module output_stage_control #(
  parameter int STEP_CYCLES  = outstage_pkg::STEP_CYC,
  parameter int START_CYCLES = outstage_pkg::SOFT_START_CYC
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  // Register port
  input  wire logic       i_reg_page,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  // Fault detectors, bit 0 left, bit 1 right
  input  wire logic [1:0] i_hp_short,
  input  wire logic [1:0] i_spk_short,
  input  wire logic       i_over_temp,
  // Routing and speaker attenuation
  output logic      [1:0] o_dac_route,
  output logic      [1:0] o_spk_feed,
  output logic      [1:0] o_spk_mute,
  output logic      [6:0] o_spk_left_level,
  output logic      [6:0] o_spk_right_level,
  // Headphone drivers
  output logic      [1:0] o_hp_pwr,
  output logic      [1:0] o_hp_cm_sel,
  output logic      [3:0] o_hp_left_gain,
  output logic      [3:0] o_hp_right_gain,
  output logic      [1:0] o_hp_mute,
  output logic      [1:0] o_hp_limit,
  output logic            o_lineout_mode,
  // Speaker drivers
  output logic      [1:0] o_spk_pwr,
  output logic      [1:0] o_spk_switch,
  // Stage soft-start settled: hp L, hp R, spk L, spk R
  output logic      [3:0] o_stage_ready
);
  import outstage_pkg::*;

  localparam int SS_W = $clog2(START_CYCLES + 1);

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    logic [7:0]           hp_ctl;
    logic [7:0]           spk_ctl;
    logic [7:0]           route;
    logic [7:0]           att_l;
    logic [7:0]           att_r;
    logic [7:0]           hpg_l;
    logic [7:0]           hpg_r;
    logic [7:0]           spg_l;
    logic [7:0]           spg_r;
    logic [7:0]           hp_cfg;
    logic [7:0]           step_ctl;
    logic                 thermal;
    logic                 lineout;
    logic [7:0]           rdata;
    logic [1:0]           spk_mute;
    logic [1:0]           spk_feed;
    logic [1:0]           hp_limit;
    logic [1:0]           spk_switch;
    logic [3:0]           pwr_prev;
    logic [3:0]           ready;
    logic [3:0][SS_W-1:0] ss_cnt;
  } ctl_state_t;

  ctl_state_t st_ff;
  ctl_state_t nxt_st;
  logic       wr0;
  logic       wr1;
  logic [3:0] pwr;
  logic [7:0] att;
  logic [7:0] rd_val;

  // Stage power vector: hp L, hp R, spk L, spk R
  assign pwr = {st_ff.spk_ctl[BIT_PWR_R], st_ff.spk_ctl[BIT_PWR_L],
                st_ff.hp_ctl[BIT_PWR_R], st_ff.hp_ctl[BIT_PWR_L]};

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always_comb begin
    nxt_st = st_ff;
    att    = 8'h00;
    rd_val = RD_UNMAP;
    wr0    = i_reg_wr && (i_reg_page == PAGE0);
    wr1    = i_reg_wr && (i_reg_page == PAGE1);

    // Register writes; status flags clear on a control write
    if (wr0 && (i_reg_addr == OFS_STEP)) begin
      nxt_st.step_ctl = i_reg_wdata;
    end
    if (wr1) begin
      case (i_reg_addr)
        OFS_HP_CTL:  nxt_st.hp_ctl  = {i_reg_wdata[7:1], 1'b0};
        OFS_SPK_CTL: nxt_st.spk_ctl = {i_reg_wdata[7:1], 1'b0};
        OFS_ROUTE:   nxt_st.route   = i_reg_wdata;
        OFS_ATT_L:   nxt_st.att_l   = i_reg_wdata;
        OFS_ATT_R:   nxt_st.att_r   = i_reg_wdata;
        OFS_HPG_L:   nxt_st.hpg_l   = i_reg_wdata;
        OFS_HPG_R:   nxt_st.hpg_r   = i_reg_wdata;
        OFS_SPG_L:   nxt_st.spg_l   = i_reg_wdata;
        OFS_SPG_R:   nxt_st.spg_r   = i_reg_wdata;
        OFS_HP_CFG:  nxt_st.hp_cfg  = i_reg_wdata;
        default: begin
        end
      endcase
    end

    // Per-channel fault handling; hardware wins over a same-cycle write
    for (int ch = 0; ch < 2; ch++) begin
      if (i_hp_short[ch]) begin
        nxt_st.hp_ctl[BIT_FLAG] = 1'b1;
        if (st_ff.hp_ctl[BIT_HP_SHUT]) begin
          nxt_st.hp_ctl[BIT_PWR_L - ch] = 1'b0;
        end
      end
      if (i_spk_short[ch]) begin
        nxt_st.spk_ctl[BIT_FLAG]       = 1'b1;
        nxt_st.spk_ctl[BIT_PWR_L - ch] = 1'b0;
      end
      nxt_st.hp_limit[ch] = i_hp_short[ch] && !st_ff.hp_ctl[BIT_HP_SHUT]
                            && st_ff.hp_ctl[BIT_PWR_L - ch];
      nxt_st.spk_switch[ch] = st_ff.spk_ctl[BIT_PWR_L - ch] && !i_over_temp
                              && !i_spk_short[ch];
      att = (ch == 0) ? st_ff.att_l : st_ff.att_r;
      nxt_st.spk_feed[ch] = att[BIT_FEED];
      nxt_st.spk_mute[ch] = !att[BIT_FEED] && (att[6:0] == ATT_MAX);
    end
    nxt_st.thermal = i_over_temp;
    nxt_st.lineout = nxt_st.hp_cfg[BIT_LINE_LO +: 2] == LINEOUT_CODE;

    // Independent soft-start timer per stage
    for (int s = 0; s < 4; s++) begin
      if (pwr[s] != st_ff.pwr_prev[s]) begin
        nxt_st.ss_cnt[s] = '0;
        nxt_st.ready[s]  = 1'b0;
      end else if (st_ff.ss_cnt[s] < SS_W'(START_CYCLES - 1)) begin
        nxt_st.ss_cnt[s] = st_ff.ss_cnt[s] + SS_W'(1);
      end else begin
        nxt_st.ready[s]  = 1'b1;
      end
    end
    nxt_st.pwr_prev = pwr;

    // Read mux; reads change nothing but the data register
    if (i_reg_page == PAGE0) begin
      case (i_reg_addr)
        OFS_THERMAL: rd_val = {6'h00, st_ff.thermal, 1'b0};
        OFS_STEP:    rd_val = st_ff.step_ctl;
        default:     rd_val = RD_UNMAP;
      endcase
    end else begin
      case (i_reg_addr)
        OFS_HP_CTL:  rd_val = st_ff.hp_ctl;
        OFS_SPK_CTL: rd_val = st_ff.spk_ctl;
        OFS_ROUTE:   rd_val = st_ff.route;
        OFS_ATT_L:   rd_val = st_ff.att_l;
        OFS_ATT_R:   rd_val = st_ff.att_r;
        OFS_HPG_L:   rd_val = st_ff.hpg_l;
        OFS_HPG_R:   rd_val = st_ff.hpg_r;
        OFS_SPG_L:   rd_val = st_ff.spg_l;
        OFS_SPG_R:   rd_val = st_ff.spg_r;
        OFS_HP_CFG:  rd_val = st_ff.hp_cfg;
        default:     rd_val = RD_UNMAP;
      endcase
    end
    if (i_reg_rd) begin
      nxt_st.rdata = rd_val;
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ******************************************************************
  // Soft-stepping attenuators, one per speaker channel
  // ******************************************************************
  logic [6:0] lvl [2];

  for (genvar g = 0; g < 2; g++) begin : g_step
    soft_stepper #(
      .STEP_CYCLES (STEP_CYCLES)
    ) u_step (
      .i_sys_clk (i_sys_clk),
      .i_arst_n  (i_arst_n),
      .i_target  ((g == 0) ? st_ff.att_l[6:0] : st_ff.att_r[6:0]),
      .i_pace    (st_ff.step_ctl[1:0]),
      .o_level   (lvl[g])
    );
  end

  // ******************************************************************
  // Outputs, all taken from registers
  // ******************************************************************
  assign o_reg_rdata       = st_ff.rdata;
  assign o_dac_route       = {st_ff.route[BIT_ROUTE_R], st_ff.route[BIT_ROUTE_L]};
  assign o_spk_feed        = st_ff.spk_feed;
  assign o_spk_mute        = st_ff.spk_mute;
  assign o_spk_left_level  = lvl[0];
  assign o_spk_right_level = lvl[1];
  assign o_hp_pwr          = {st_ff.hp_ctl[BIT_PWR_R], st_ff.hp_ctl[BIT_PWR_L]};
  assign o_hp_cm_sel       = st_ff.hp_ctl[BIT_CM_LO +: 2];
  assign o_hp_left_gain    = st_ff.hpg_l[BIT_HPG_LO +: 4];
  assign o_hp_right_gain   = st_ff.hpg_r[BIT_HPG_LO +: 4];
  assign o_hp_mute         = {st_ff.hpg_r[BIT_HP_MUTE], st_ff.hpg_l[BIT_HP_MUTE]};
  assign o_hp_limit        = st_ff.hp_limit;
  assign o_lineout_mode    = st_ff.lineout;
  assign o_spk_pwr         = {st_ff.spk_ctl[BIT_PWR_R], st_ff.spk_ctl[BIT_PWR_L]};
  assign o_spk_switch      = st_ff.spk_switch;
  assign o_stage_ready     = st_ff.ready;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  a_hp_shut_clear: assert property (
    st_ff.hp_ctl[BIT_HP_SHUT] && i_hp_short != 2'h0
    |=> (o_hp_pwr & $past(i_hp_short)) == 2'h0)
    else $error("headphone power not cleared on short");

  a_hp_limit_mode: assert property (
    i_hp_short[1] && !st_ff.hp_ctl[BIT_HP_SHUT] && o_hp_pwr[1] && !i_reg_wr
    |=> o_hp_limit[1] && o_hp_pwr[1])
    else $error("headphone limit mode misbehaved");

  a_spk_shut_clear: assert property (
    i_spk_short != 2'h0 |=> (o_spk_pwr & $past(i_spk_short)) == 2'h0
    ##1 (o_spk_switch & $past(i_spk_short, 2)) == 2'h0)
    else $error("speaker stage not shut down on overcurrent");

  a_flags_set: assert property (
    (i_hp_short != 2'h0) |=> st_ff.hp_ctl[BIT_FLAG])
    else $error("headphone short flag not set");

  a_spk_flag_set: assert property (
    (i_spk_short != 2'h0) |=> st_ff.spk_ctl[BIT_FLAG])
    else $error("speaker short flag not set");

  a_thermal_stop: assert property (
    i_over_temp |=> !o_spk_switch[0] && !o_spk_switch[1] && st_ff.thermal)
    else $error("speaker switching during overheat");

  a_mute_decode: assert property (
    (st_ff.att_l == {1'b0, ATT_MAX}) |=> o_spk_mute[0] && !o_spk_feed[0])
    else $error("left speaker mute decode wrong");

  a_feed_route: assert property (
    st_ff.att_r[BIT_FEED] |=> o_spk_feed[1] && !o_spk_mute[1])
    else $error("right speaker feed wrong");

  a_soft_restart: assert property (
    $changed(pwr[2]) |=> !o_stage_ready[2] [*3])
    else $error("stage ready during soft start");

  a_other_chan: assert property (
    i_spk_short == 2'h1 && !i_reg_wr && o_spk_pwr[1] |=> o_spk_pwr[1])
    else $error("fault on one channel hit the other");

  a_read_clean: assert property (
    i_reg_rd && !i_reg_wr && i_hp_short == 2'h0 |=> $stable(st_ff.hp_ctl))
    else $error("read changed control register");

  a_rewrite_pwr: assert property (
    wr1 && i_reg_addr == OFS_HP_CTL && i_reg_wdata[BIT_PWR_L] && !i_hp_short[0]
    |=> o_hp_pwr[0])
    else $error("headphone power rewrite ignored");

  a_route_write: assert property (
    wr1 && i_reg_addr == OFS_ROUTE && i_reg_wdata[BIT_ROUTE_L] |=> o_dac_route[0])
    else $error("left routing bit not applied");

  a_lineout_set: assert property (
    wr1 && i_reg_addr == OFS_HP_CFG && i_reg_wdata[BIT_LINE_LO +: 2] == LINEOUT_CODE
    |=> o_lineout_mode)
    else $error("lineout mode not entered");

  a_hp_power_off: assert property (
    wr1 && i_reg_addr == OFS_HP_CTL && !i_reg_wdata[BIT_PWR_R]
    |=> !o_hp_pwr[1])
    else $error("right headphone stayed powered");

  a_spk_power_on: assert property (
    wr1 && i_reg_addr == OFS_SPK_CTL && i_reg_wdata[BIT_PWR_R] && !i_spk_short[1]
    |=> o_spk_pwr[1])
    else $error("right speaker power write ignored");

  a_pace_jump: assert property (
    st_ff.step_ctl[1:0] == PACE_NONE && !i_reg_wr
    |=> o_spk_left_level == st_ff.att_l[6:0])
    else $error("unstepped level did not jump");

  a_hp_mute_write: assert property (
    wr1 && i_reg_addr == OFS_HPG_L && i_reg_wdata[BIT_HP_MUTE]
    |=> o_hp_mute[0])
    else $error("left headphone mute not applied");

  a_cm_select: assert property (
    wr1 && i_reg_addr == OFS_HP_CTL && i_reg_wdata[BIT_CM_LO + 1]
    |=> o_hp_cm_sel[1])
    else $error("common-mode select not applied");

endmodule

`default_nettype wire

// File: rtl/outstage_pkg.sv
/*
  Constants for the audio output-stage register bank: register offsets,
  field positions, reset values and timing counts.
  Assumes a 40 MHz register clock and a paged 8-bit register space.
*/
package outstage_pkg;

  // ******************************************************************
  // Register pages and offsets
  // ******************************************************************
  localparam logic       PAGE0          = 1'h0;
  localparam logic       PAGE1          = 1'h1;
  localparam logic [7:0] OFS_THERMAL    = 8'h03;
  localparam logic [7:0] OFS_HP_CTL     = 8'h1F;
  localparam logic [7:0] OFS_SPK_CTL    = 8'h20;
  localparam logic [7:0] OFS_ROUTE      = 8'h23;
  localparam logic [7:0] OFS_ATT_L      = 8'h26;
  localparam logic [7:0] OFS_ATT_R      = 8'h27;
  localparam logic [7:0] OFS_HPG_L      = 8'h28;
  localparam logic [7:0] OFS_HPG_R      = 8'h29;
  localparam logic [7:0] OFS_SPG_L      = 8'h2A;
  localparam logic [7:0] OFS_SPG_R      = 8'h2B;
  localparam logic [7:0] OFS_HP_CFG     = 8'h2C;
  localparam logic [7:0] OFS_STEP       = 8'h3F;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int BIT_PWR_L     = 7;  // Left stage power in driver control
  localparam int BIT_PWR_R     = 6;  // Right stage power in driver control
  localparam int BIT_HP_SHUT   = 1;  // Short action: 1 shutdown, 0 limit
  localparam int BIT_FLAG      = 0;  // Short-circuit status flag
  localparam int BIT_CM_LO     = 3;  // Common-mode select, two bits
  localparam int BIT_ROUTE_L   = 6;  // Left DAC to left attenuator
  localparam int BIT_ROUTE_R   = 2;  // Right DAC to right attenuator
  localparam int BIT_FEED      = 7;  // Attenuator to speaker amplifier
  localparam int BIT_HPG_LO    = 3;  // Headphone gain, four bits
  localparam int BIT_HP_MUTE   = 2;  // Headphone driver mute
  localparam int BIT_LINE_LO   = 1;  // Lineout mode field, two bits
  localparam int BIT_OTEMP     = 1;  // Over-temperature flag
  localparam logic [1:0] LINEOUT_CODE = 2'h3;
  localparam logic [6:0] ATT_MAX      = 7'h7F;
  localparam logic [1:0] PACE_NONE    = 2'h3;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam logic [7:0] RD_UNMAP  = 8'h00;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CLK_MHZ         = 40;
  localparam int STEP_TIME_NS    = 1000;   // Base time per soft step
  localparam int SOFT_START_NS   = 10000;  // Stage soft-start time
  localparam int STEP_CYC        = (STEP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SOFT_START_CYC  = (SOFT_START_NS * CLK_MHZ + 999) / 1000;

endpackage

// File: rtl/soft_stepper.sv
/*
  One soft-stepping attenuator: moves the applied level one code at a
  time toward the programmed target at a pace set by a two-bit field,
  or straight to the target when the field is PACE_NONE.
  Assumes the target and pace inputs are synchronous to i_sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module soft_stepper #(
  parameter int STEP_CYCLES = outstage_pkg::STEP_CYC
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  // Control
  input  wire logic [6:0] i_target,
  input  wire logic [1:0] i_pace,
  // Applied level
  output logic      [6:0] o_level
);
  import outstage_pkg::*;

  localparam int CNT_W = $clog2(STEP_CYCLES * 4 + 1);

  typedef struct packed {
    logic [6:0]       level;
    logic [CNT_W-1:0] cnt;
  } step_state_t;

  step_state_t st_ff;
  step_state_t nxt_st;
  logic [CNT_W-1:0] limit;

  // ******************************************************************
  // Stepping toward the target
  // ******************************************************************
  always_comb begin
    nxt_st = st_ff;
    limit  = CNT_W'(STEP_CYCLES) << i_pace;
    if (i_pace == PACE_NONE) begin
      nxt_st.level = i_target;
      nxt_st.cnt   = '0;
    end else if (st_ff.level != i_target) begin
      if (st_ff.cnt >= limit - CNT_W'(1)) begin
        nxt_st.cnt = '0;
        if (st_ff.level < i_target) begin
          nxt_st.level = st_ff.level + 7'h01;
        end else begin
          nxt_st.level = st_ff.level - 7'h01;
        end
      end else begin
        nxt_st.cnt = st_ff.cnt + CNT_W'(1);
      end
    end else begin
      nxt_st.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_level = st_ff.level;

endmodule

`default_nettype wire

// File: tb/test_output_stage_control.sv
/*
  Self-checking bench for the output-stage register bank: register
  reads and writes, routing, attenuation and soft stepping, driver power,
  short-circuit handling and the over-temperature flag.
  Assumes the design package is compiled first; no partner model.
*/
`timescale 1ns/1ps
`default_nettype none

module test_output_stage_control;
  import outstage_pkg::*;

  localparam int STEP = 2;
  localparam int START = 4;

  logic       i_sys_clk = 1'b0, i_arst_n = 1'b0, i_reg_page = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
  logic       i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_over_temp = 1'b0;
  logic [1:0] i_hp_short = 2'h0, i_spk_short = 2'h0;
  logic [7:0] o_reg_rdata, d;
  logic [1:0] o_dac_route, o_spk_feed, o_spk_mute, o_hp_pwr, o_hp_cm_sel;
  logic [1:0] o_hp_mute, o_hp_limit, o_spk_pwr, o_spk_switch;
  logic [6:0] o_spk_left_level, o_spk_right_level, tgt;
  logic [3:0] o_hp_left_gain, o_hp_right_gain, o_stage_ready;
  logic       o_lineout_mode;
  logic [7:0] exp_q[$];
  int         n_fail = 0, comparisons = 0, n, per;

  output_stage_control #(.STEP_CYCLES(STEP), .START_CYCLES(START)) dut (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_reg_page(i_reg_page),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_hp_short(i_hp_short),
    .i_spk_short(i_spk_short), .i_over_temp(i_over_temp),
    .o_dac_route(o_dac_route), .o_spk_feed(o_spk_feed), .o_spk_mute(o_spk_mute),
    .o_spk_left_level(o_spk_left_level), .o_spk_right_level(o_spk_right_level),
    .o_hp_pwr(o_hp_pwr), .o_hp_cm_sel(o_hp_cm_sel), .o_hp_left_gain(o_hp_left_gain),
    .o_hp_right_gain(o_hp_right_gain), .o_hp_mute(o_hp_mute), .o_hp_limit(o_hp_limit),
    .o_lineout_mode(o_lineout_mode), .o_spk_pwr(o_spk_pwr),
    .o_spk_switch(o_spk_switch), .o_stage_ready(o_stage_ready));

  // ***************************************************************
  // Clock, watchdog and closing
  // ***************************************************************
  always #12.5 i_sys_clk = ~i_sys_clk;

  // Cuts a hang short well beyond the expected run length
  initial begin
    #(25 * 20000);
    n_fail++;
    give_verdict();
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ***************************************************************
  // Drivers and checks
  // ***************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic pg, input logic [7:0] a, input logic [7:0] v);
    @(negedge i_sys_clk);
    i_reg_page = pg; i_reg_addr = a; i_reg_wdata = v; i_reg_wr = 1'b1;
    @(negedge i_sys_clk);
    i_reg_wr = 1'b0;
  endtask

  // Notes the expected byte, then strobes one read
  task automatic rd(input logic pg, input logic [7:0] a, input logic [7:0] v);
    @(negedge i_sys_clk);
    exp_q.push_back(v);
    i_reg_page = pg; i_reg_addr = a; i_reg_rd = 1'b1;
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge i_sys_clk);
  endtask

  task automatic do_reset();
    i_arst_n = 1'b0;
    cyc(8);
    i_arst_n = 1'b1;
  endtask

  // Read-data monitor: compares against the oldest note
  initial begin
    forever begin
      @(posedge i_sys_clk);
      if (i_reg_rd === 1'b1) begin
        @(negedge i_sys_clk);
        if (exp_q.size() == 0) begin
          chk(32'h1, 32'h0);
        end else begin
          chk({24'h0, o_reg_rdata}, {24'h0, exp_q.pop_front()});
        end
      end
    end
  end

  // ***************************************************************
  // Tests
  // ***************************************************************
  initial begin
    void'($urandom(70039));
    do_reset();
    // Reset values and unmapped reads
    chk({o_hp_pwr, o_spk_pwr, o_dac_route, o_spk_feed}, 32'h0);
    rd(PAGE1, OFS_HP_CTL, RST_REG);
    rd(PAGE1, OFS_ATT_L, RST_REG);
    rd(PAGE0, OFS_THERMAL, RST_REG);
    rd(PAGE1, 8'h7E, RD_UNMAP);
    $display("test reset done");
    // Random read-back and decoded fields
    repeat (4) begin
      d = 8'($urandom());
      wr(PAGE1, OFS_ROUTE, d);
      rd(PAGE1, OFS_ROUTE, d);
      chk(o_dac_route, {d[BIT_ROUTE_R], d[BIT_ROUTE_L]});
      d = 8'($urandom());
      wr(PAGE1, OFS_HPG_L, d);
      wr(PAGE1, OFS_HPG_R, ~d);
      rd(PAGE1, OFS_HPG_R, ~d);
      chk({o_hp_left_gain, o_hp_right_gain}, {d[6:3], ~d[6:3]});
      chk(o_hp_mute, {~d[BIT_HP_MUTE], d[BIT_HP_MUTE]});
      wr(PAGE1, OFS_HP_CFG, d);
      rd(PAGE1, OFS_HP_CFG, d);
      chk(o_lineout_mode, d[2:1] == LINEOUT_CODE);
      d = {3'($urandom()), 5'h0};
      wr(PAGE1, OFS_HP_CTL, {d[7:6], 1'b0, d[5], 4'h0});
      chk({o_hp_pwr, o_hp_cm_sel}, {d[6], d[7], d[5], 1'b0});
    end
    wr(PAGE1, OFS_HP_CFG, {5'h00, LINEOUT_CODE, 1'b0});
    chk(o_lineout_mode, 1'b1);
    wr(PAGE0, OFS_THERMAL, 8'hFF);
    rd(PAGE0, OFS_THERMAL, 8'h00);
    $display("test fields done");
    // Immediate jump, mute code and amplifier feed
    wr(PAGE0, OFS_STEP, {6'h0, PACE_NONE});
    wr(PAGE1, OFS_ATT_R, 8'h45);
    cyc(1);
    chk(o_spk_right_level, 7'h45);
    chk(o_spk_feed[1], 1'b0);
    wr(PAGE1, OFS_ATT_L, {1'b0, ATT_MAX});
    cyc(1);
    chk({o_spk_mute[0], o_spk_feed[0]}, 2'h2);
    wr(PAGE1, OFS_ATT_L, 8'h90);
    cyc(1);
    chk({o_spk_mute[0], o_spk_feed[0], o_spk_left_level}, {2'h1, 7'h10});
    wr(PAGE1, OFS_ATT_R, 8'hC5);
    cyc(1);
    chk({o_spk_mute[1], o_spk_feed[1], o_spk_right_level}, {2'h1, 7'h45});
    // Soft-step pace for each slow setting, two codes each
    for (int p = 0; p < 3; p++) begin
      tgt = (p == 1) ? 7'h10 : 7'h12;
      per = STEP << p;
      wr(PAGE0, OFS_STEP, 8'(p));
      wr(PAGE1, OFS_ATT_L, {1'b1, tgt});
      n = 0;
      while (o_spk_left_level !== tgt && n < 200) begin
        cyc(1);
        n++;
      end
      chk(n >= per && n <= 2 * per + 2, 1'b1);
      chk(o_spk_left_level, tgt);
    end
    $display("test attenuation done");
    // Headphone short in limit mode, flag sticky over reads
    wr(PAGE1, OFS_HP_CTL, 8'hC0);
    wr(PAGE1, OFS_SPK_CTL, 8'hC0);
    cyc(START + 8);
    chk(o_stage_ready, 4'hF);
    chk(o_spk_switch, 2'h3);
    i_hp_short = 2'h3;
    cyc(3);
    chk({o_hp_limit, o_hp_pwr}, 4'hF);
    i_hp_short = 2'h0;
    rd(PAGE1, OFS_HP_CTL, 8'hC1);
    rd(PAGE1, OFS_HP_CTL, 8'hC1);
    // Shutdown mode: faulted side only, persisting fault trips again
    wr(PAGE1, OFS_HP_CTL, 8'hC2);
    i_hp_short = 2'h2;
    cyc(3);
    chk(o_hp_pwr, 2'h1);
    rd(PAGE1, OFS_HP_CTL, 8'h83);
    wr(PAGE1, OFS_HP_CTL, 8'hC2);
    cyc(3);
    chk(o_hp_pwr, 2'h1);
    i_hp_short = 2'h0;
    wr(PAGE1, OFS_HP_CTL, 8'hC2);
    cyc(3);
    chk({o_hp_pwr, o_hp_limit}, 4'hC);
    $display("test headphone faults done");
    // Speaker overcurrent shuts the stage down, other side untouched
    i_spk_short = 2'h1;
    cyc(3);
    chk({o_spk_pwr, o_spk_switch}, 4'hA);
    chk(o_stage_ready[3:2], 2'h2);
    chk(o_hp_pwr, 2'h3);
    rd(PAGE1, OFS_SPK_CTL, 8'h41);
    wr(PAGE1, OFS_SPK_CTL, 8'hC0);
    cyc(3);
    chk(o_spk_pwr, 2'h2);
    i_spk_short = 2'h0;
    wr(PAGE1, OFS_SPK_CTL, 8'hC0);
    cyc(3);
    chk({o_spk_pwr, o_spk_switch}, 4'hF);
    // Over-temperature stops switching, resumes when cooled
    i_over_temp = 1'b1;
    cyc(3);
    chk({o_spk_switch, o_spk_pwr}, 4'h3);
    rd(PAGE0, OFS_THERMAL, 8'h02);
    i_over_temp = 1'b0;
    cyc(3);
    chk(o_spk_switch, 2'h3);
    $display("test speaker faults done");
    // Master reset in mid-run clears every register
    do_reset();
    chk({o_hp_pwr, o_spk_pwr, o_spk_switch}, 32'h0);
    rd(PAGE1, OFS_SPK_CTL, RST_REG);
    rd(PAGE1, OFS_ATT_L, RST_REG);
    cyc(4);
    $display("test master reset done");
    give_verdict();
  end

endmodule

`default_nettype wire
